// *** src/acr_pkg.sv ***
package acr_pkg;

   // ========
   // Register map (byte addresses)
   // ========
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_DIAG = 8'h0c;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_SENSE = 8'h14;

   // ========
   // Control register fields
   // ========
   localparam int CTRL_KIND_LSB = 0;
   localparam int CTRL_STATE_LSB = 3;
   localparam int CTRL_IRQ_EN = 5;
   localparam int CTRL_RESTART = 6;
   localparam logic [2:0] KIND_RESET = 3'h0;
   localparam logic [1:0] STATE_RESET = 2'h0;

   // Element kinds
   localparam logic [2:0] KIND_CE = 3'h0;
   localparam logic [2:0] KIND_SE = 3'h1;
   localparam logic [2:0] KIND_IO_COMPUTING_ELEMENT = 3'h2;
   localparam logic [2:0] KIND_TAPE = 3'h3;
   localparam logic [2:0] KIND_PAM = 3'h4;
   localparam logic [2:0] KIND_DISK = 3'h5;

   // ========
   // Configuration control register: permission field + parity
   // ========
   localparam int CFG_W = 9;
   localparam int CFG_PERM_W = 8;
   localparam int CFG_PAR_BIT = 8;
   // Odd parity over all nine bits; reset value is consistent
   localparam logic [8:0] CFG_RESET = 9'h1ff;

   // ========
   // Status, diagnose and sense fields
   // ========
   localparam int ST_CHECKSTOP = 0;
   localparam int ST_STOPPED = 1;
   localparam int ST_OTC = 2;
   localparam int ST_BATTERY = 3;
   localparam int ST_PARITY = 4;
   localparam int ST_ATTN = 5;
   localparam int ST_WAIT = 6;

   localparam int DIAG_W = 2;
   localparam int DIAG_OTC = 0;
   localparam int DIAG_BAT = 1;
   localparam logic [1:0] DIAG_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   localparam int SENSE_B4_OTC = 3;
   localparam int SENSE_ADP_OTC = 8;
   localparam int SENSE_ADP_PAR = 9;

   // ========
   // Pin input vector positions
   // ========
   localparam int IN_PWR_FAULT = 0;
   localparam int IN_PWR_DOWN = 1;
   localparam int IN_OT_SENSE = 2;
   localparam int IN_OT_TEST = 3;
   localparam int IN_BAT_SENSE = 4;
   localparam int IN_BAT_TEST = 5;
   localparam int IN_LOGIC_ERR = 6;
   localparam int IN_NO_CONT = 7;
   localparam int IN_LOGOUT_STOP = 8;
   localparam int IN_CFG_CMD = 9;
   localparam int IN_OP_END = 10;
   localparam int IN_SELECT = 11;
   localparam int IN_SRC_LSB = 12;
   localparam int IN_DATA_LSB = 15;
   localparam int IN_W = 24;

   // ========
   // Timing
   // ========
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOGOUT_WAIT_NS = 2500;
   localparam int LOGOUT_WAIT_CYC = (LOGOUT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_CNT_W = 9;

   typedef enum logic [1:0] {
      ACR_RUN = 2'b00,
      ACR_WAIT = 2'b01,
      ACR_STOP = 2'b10
   } acr_stop_t;

endpackage : acr_pkg

// *** src/acr_element.sv ***
// What this block does
// [RULE1] Power fault or power-down raises element check
// [RULE2] Computing element over-temperature interrupts only itself
// [RULE3] Storage over-temperature sends element check to all
// [RULE4] I/O element over-temperature reported, function unimpaired
// [RULE5] Tape unit: attention only for over-temperature
// [RULE6] Adapter: attention; sense holds temperature, parity
// [RULE7] Disk: pulse check, sense byte 4 bit 3
// [RULE8] Manual test input mimics real over-temperature
// [RULE9] Battery switch-over signal, with manual test input
// [RULE10] Computing element battery signal interrupts only itself
// [RULE11] Storage battery signal sent as element check
// [RULE12] I/O element drives battery signal as level
// [RULE13] Parity error during set-config pulses battery line
// [RULE14] Continuous parity check; error sends element check
// [RULE15] Parity check suppressed while register loads
// [RULE16] Empty permission field bypassed unless state zero
// [RULE17] State zero, empty field: reject every command
// [RULE18] Parity error leaves other operation untouched
// [RULE19] Checkstop always issues element check
// [RULE20] Unable to continue: checkstop, level element check
// [RULE21] Storage error: pulse, wait for logout-stop window
// [RULE22] Logout-stop: checkstop, level check, stopped signal
// [RULE23] Level-set diagnose bits re-set after read clears
// [RULE24] Interrupt needs mask bit and enable bit
// [RULE25] Pulse one cycle; level holds until restart
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
module acr_element
   import acr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic power_fault,
   input wire logic power_down,
   input wire logic over_temp_sense,
   input wire logic over_temp_test,
   input wire logic battery_sense,
   input wire logic battery_test,
   input wire logic logic_error,
   input wire logic unable_to_continue,
   input wire logic logout_stop_req,
   input wire logic cfg_cmd,
   input wire logic [2:0] cfg_src,
   input wire logic [8:0] cfg_data,
   input wire logic op_end,
   input wire logic select_attempt,
   output logic element_check_signal,
   output logic battery_power_signal,
   output logic stopped_signal,
   output logic ext_interrupt,
   output logic status_attention,
   output logic cfg_accept,
   output logic cfg_reject
);

   // ========
   // Pin synchronisers
   // ========
   logic [IN_W-1:0] pin_raw;
   logic [IN_W-1:0] sync1;
   logic [IN_W-1:0] sync2;
   logic [IN_W-1:0] sync3;

   assign pin_raw = {cfg_data, cfg_src, select_attempt, op_end, cfg_cmd,
                     logout_stop_req, unable_to_continue, logic_error,
                     battery_test, battery_sense, over_temp_test,
                     over_temp_sense, power_down, power_fault};

   // Multi-bit source and data must be stable around the command edge
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   logic [IN_W-1:0] rise;
   logic power_bad;
   logic over_temperature_check;
   logic bat;
   logic otc_rise;
   logic [2:0] src;
   logic [CFG_W-1:0] cmd_data;

   assign rise = sync2 & ~sync3;
   assign power_bad = sync2[IN_PWR_FAULT] | sync2[IN_PWR_DOWN]; // [RULE1]
   assign over_temperature_check = sync2[IN_OT_SENSE] | sync2[IN_OT_TEST]; // [RULE8]
   assign bat = sync2[IN_BAT_SENSE] | sync2[IN_BAT_TEST]; // [RULE9]
   assign otc_rise = over_temperature_check & ~(sync3[IN_OT_SENSE] | sync3[IN_OT_TEST]);
   assign src = sync2[IN_SRC_LSB +: 3];
   assign cmd_data = sync2[IN_DATA_LSB +: CFG_W];

   // ========
   // Control and configuration registers
   // ========
   logic [2:0] kind;
   logic [1:0] elem_state;
   logic irq_en;
   logic [CFG_W-1:0] cfg;
   logic cfg_load_q;
   logic [DIAG_W-1:0] diag_mask;
   logic [2:0] next_kind;
   logic [1:0] next_elem_state;
   logic next_irq_en;
   logic [CFG_W-1:0] next_cfg;
   logic next_cfg_load_q;
   logic [DIAG_W-1:0] next_diag_mask;
   logic next_cfg_accept;
   logic next_cfg_reject;

   logic wr_ctrl;
   logic wr_cfg;
   logic restart;
   logic is_ce;
   logic is_se;
   logic is_io_computing_element;
   logic perm_empty;
   logic cmd_ok;
   logic parity_bad;
   logic parity_err;

   assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_cfg = reg_wr && (reg_addr == ADDR_CFG);
   assign restart = wr_ctrl && reg_wdata[CTRL_RESTART];
   assign is_ce = (kind == KIND_CE);
   assign is_se = (kind == KIND_SE);
   assign is_io_computing_element = (kind == KIND_IO_COMPUTING_ELEMENT);
   assign perm_empty = (cfg[CFG_PERM_W-1:0] == '0);
   // Bypass only outside state zero; in state zero an empty field passes nothing
   assign cmd_ok = cfg[src] || (perm_empty && (elem_state != 2'h0)); // [RULE16] [RULE17]
   assign parity_bad = ~(^cfg);
   // Checked every cycle, held off around a load
   assign parity_err = parity_bad && !cfg_load_q && !wr_cfg; // [RULE14] [RULE15]

   always_comb begin
      next_kind = kind;
      next_elem_state = elem_state;
      next_irq_en = irq_en;
      next_cfg = cfg;
      next_diag_mask = diag_mask;
      next_cfg_load_q = 1'b0;
      next_cfg_accept = 1'b0;
      next_cfg_reject = 1'b0;
      if (wr_ctrl) begin
         next_kind = reg_wdata[CTRL_KIND_LSB +: 3];
         next_elem_state = reg_wdata[CTRL_STATE_LSB +: 2];
         next_irq_en = reg_wdata[CTRL_IRQ_EN];
      end
      if (reg_wr && (reg_addr == ADDR_MASK)) begin
         next_diag_mask = reg_wdata[DIAG_W-1:0];
      end
      if (wr_cfg) begin
         next_cfg = reg_wdata[CFG_W-1:0];
         next_cfg_load_q = 1'b1;
      end else if (rise[IN_CFG_CMD]) begin
         if (cmd_ok) begin // [RULE16]
            next_cfg = cmd_data;
            next_cfg_load_q = 1'b1;
            next_cfg_accept = 1'b1;
         end else begin
            next_cfg_reject = 1'b1; // [RULE17]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         kind <= KIND_RESET;
         elem_state <= STATE_RESET;
         irq_en <= 1'b0;
         cfg <= CFG_RESET;
         cfg_load_q <= 1'b0;
         diag_mask <= MASK_RESET;
         cfg_accept <= 1'b0;
         cfg_reject <= 1'b0;
      end else begin
         kind <= next_kind;
         elem_state <= next_elem_state;
         irq_en <= next_irq_en;
         cfg <= next_cfg;
         cfg_load_q <= next_cfg_load_q;
         diag_mask <= next_diag_mask;
         cfg_accept <= next_cfg_accept;
         cfg_reject <= next_cfg_reject;
      end
   end

   // ========
   // Checkstop sequencing
   // ========
   acr_stop_t stop_st;
   acr_stop_t next_stop_st;
   logic [WAIT_CNT_W-1:0] wait_cnt;
   logic [WAIT_CNT_W-1:0] next_wait_cnt;
   logic err_pulse;

   // Logic error pulses check on storage, computing and I/O computing elements; only storage opens the logout-stop window
   assign err_pulse = rise[IN_LOGIC_ERR] && (is_se || is_ce || is_io_computing_element);

   always_comb begin
      next_stop_st = stop_st;
      next_wait_cnt = wait_cnt;
      case (stop_st)
         ACR_RUN: begin
            if ((is_ce || is_io_computing_element) && rise[IN_NO_CONT]) begin
               next_stop_st = ACR_STOP; // [RULE20]
            end else if (is_se && rise[IN_LOGIC_ERR]) begin
               next_stop_st = ACR_WAIT; // [RULE21]
               next_wait_cnt = WAIT_CNT_W'(LOGOUT_WAIT_CYC - 1);
            end
         end
         ACR_WAIT: begin
            if (sync2[IN_LOGOUT_STOP]) begin
               next_stop_st = ACR_STOP; // [RULE22]
            end else if (wait_cnt == '0) begin
               next_stop_st = ACR_RUN; // [RULE21]
            end else begin
               next_wait_cnt = wait_cnt - 1'b1;
            end
         end
         ACR_STOP: begin
            if (restart) begin
               next_stop_st = ACR_RUN; // [RULE25]
            end
         end
         default: begin
            next_stop_st = ACR_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stop_st <= ACR_RUN;
         wait_cnt <= '0;
      end else begin
         stop_st <= next_stop_st;
         wait_cnt <= next_wait_cnt;
      end
   end

   // ========
   // Outgoing check, battery and stopped signals
   // ========
   logic parity_q;
   logic next_parity_q;
   logic elc_level;
   logic elc_pulse;
   logic bat_pulse;
   logic next_elc;
   logic next_bat_sig;
   logic next_stopped;

   assign next_parity_q = parity_err;
   // Temperature and battery levels have no known end, so they stay level
   assign elc_level = power_bad // [RULE1]
                    | (over_temperature_check && (is_se || is_io_computing_element)) // [RULE3] [RULE4]
                    | (bat && is_se) // [RULE11]
                    | (stop_st == ACR_STOP); // [RULE19] [RULE20] [RULE22]
   assign elc_pulse = (otc_rise && kind == KIND_DISK) // [RULE7]
                    | (parity_err && !parity_q) // [RULE14] [RULE18]
                    | err_pulse; // [RULE21]
   assign next_elc = elc_level | elc_pulse; // [RULE25]
   // A pulse against the level shows as a one-cycle inversion
   assign bat_pulse = is_io_computing_element && rise[IN_CFG_CMD] && parity_bad; // [RULE13]
   assign next_bat_sig = (is_io_computing_element && bat) ^ bat_pulse; // [RULE12]
   assign next_stopped = is_se && (stop_st == ACR_STOP); // [RULE22]

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         parity_q <= 1'b0;
         element_check_signal <= 1'b0;
         battery_power_signal <= 1'b0;
         stopped_signal <= 1'b0;
      end else begin
         parity_q <= next_parity_q;
         element_check_signal <= next_elc;
         battery_power_signal <= next_bat_sig;
         stopped_signal <= next_stopped;
      end
   end

   // ========
   // Own diagnose register and interrupt request
   // ========
   logic [DIAG_W-1:0] diag;
   logic [DIAG_W-1:0] next_diag;
   logic [DIAG_W-1:0] diag_set;
   logic next_ext_int;
   logic rd_diag;

   assign rd_diag = reg_rd && (reg_addr == ADDR_DIAG);
   // Only this element sees its own temperature and battery bits
   assign diag_set[DIAG_OTC] = is_ce && over_temperature_check; // [RULE2] [RULE8]
   assign diag_set[DIAG_BAT] = is_ce && bat; // [RULE10]

   always_comb begin
      next_diag = diag;
      if (rd_diag) begin
         next_diag = '0;
      end
      // Set beats clear, so a held level re-sets right after a read
      next_diag = next_diag | diag_set; // [RULE23]
      next_ext_int = irq_en && |(diag & diag_mask); // [RULE24]
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         diag <= DIAG_RESET;
         ext_interrupt <= 1'b0;
      end else begin
         diag <= next_diag;
         ext_interrupt <= next_ext_int;
      end
   end

   // ========
   // Attention status and sense data
   // ========
   logic attn_pend;
   logic next_attn_pend;
   logic next_attn;
   logic disk_sense;
   logic next_disk_sense;
   logic adp_par;
   logic next_adp_par;
   logic is_io_unit;
   logic present;

   assign is_io_unit = (kind == KIND_TAPE) || (kind == KIND_PAM);
   assign present = rise[IN_OP_END] || rise[IN_SELECT];

   always_comb begin
      next_attn_pend = attn_pend;
      next_attn = 1'b0;
      next_disk_sense = disk_sense;
      next_adp_par = adp_par;
      // Presented only at end of operation or on selection
      if (attn_pend && present) begin
         next_attn = 1'b1; // [RULE5] [RULE6]
         next_attn_pend = 1'b0;
      end
      if (otc_rise && is_io_unit) begin
         next_attn_pend = 1'b1; // [RULE5] [RULE6]
      end
      if (reg_rd && (reg_addr == ADDR_SENSE)) begin
         next_disk_sense = 1'b0;
         next_adp_par = 1'b0;
      end
      if (over_temperature_check && kind == KIND_DISK) begin
         next_disk_sense = 1'b1; // [RULE7]
      end
      if (parity_err && kind == KIND_PAM) begin
         next_adp_par = 1'b1; // [RULE6]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         attn_pend <= 1'b0;
         status_attention <= 1'b0;
         disk_sense <= 1'b0;
         adp_par <= 1'b0;
      end else begin
         attn_pend <= next_attn_pend;
         status_attention <= next_attn;
         disk_sense <= next_disk_sense;
         adp_par <= next_adp_par;
      end
   end

   // ========
   // Register read port
   // ========
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CTRL: begin
               next_rdata[CTRL_KIND_LSB +: 3] = kind;
               next_rdata[CTRL_STATE_LSB +: 2] = elem_state;
               next_rdata[CTRL_IRQ_EN] = irq_en;
            end
            ADDR_CFG: begin
               next_rdata[CFG_W-1:0] = cfg;
            end
            ADDR_STATUS: begin
               next_rdata[ST_CHECKSTOP] = (stop_st == ACR_STOP);
               next_rdata[ST_STOPPED] = stopped_signal;
               next_rdata[ST_OTC] = over_temperature_check;
               next_rdata[ST_BATTERY] = bat;
               next_rdata[ST_PARITY] = parity_err;
               next_rdata[ST_ATTN] = attn_pend;
               next_rdata[ST_WAIT] = (stop_st == ACR_WAIT);
            end
            ADDR_DIAG: begin
               next_rdata[DIAG_W-1:0] = diag;
            end
            ADDR_MASK: begin
               next_rdata[DIAG_W-1:0] = diag_mask;
            end
            ADDR_SENSE: begin
               next_rdata[SENSE_B4_OTC] = disk_sense;
               next_rdata[SENSE_ADP_OTC] = over_temperature_check && kind == KIND_PAM;
               next_rdata[SENSE_ADP_PAR] = adp_par;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : acr_element

// *** testbench/acr_element_asserts.sv ***
`timescale 1ns/1ns
module acr_element_asserts (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic power_fault,
   input wire logic logout_stop_req,
   input wire logic cfg_cmd,
   input wire logic op_end,
   input wire logic select_attempt,
   input wire logic element_check_signal,
   input wire logic stopped_signal,
   input wire logic status_attention,
   input wire logic cfg_accept,
   input wire logic cfg_reject
);
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // ========
   // Cycles since stop request, end of operation or selection
   logic [3:0] since_stop, next_since_stop, since_op, next_since_op;
   always_comb begin
      next_since_stop = since_stop + {3'h0, since_stop != 4'hf};
      next_since_op = since_op + {3'h0, since_op != 4'hf};
      if (logout_stop_req)
         next_since_stop = 4'h0;
      if (op_end || select_attempt)
         next_since_op = 4'h0;
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         since_stop <= 4'hf;
         since_op <= 4'hf;
      end else begin
         since_stop <= next_since_stop;
         since_op <= next_since_op;
      end
   end
   // ========
   // Properties
   property p_power_level;
      power_fault [*5] |-> element_check_signal;
   endproperty
   a_power_level: assert property (p_power_level) else $error("power unreported");
   property p_stop_cause;
      $rose(stopped_signal) |-> since_stop < 4'h8;
   endproperty
   a_stop_cause: assert property (p_stop_cause) else $error("stop unrequested");
   property p_stop_check;
      stopped_signal |-> element_check_signal;
   endproperty
   a_stop_check: assert property (p_stop_check) else $error("stop no check");
   property p_stop_hold;
      stopped_signal && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2) |=> stopped_signal;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop dropped");
   property p_acc_pulse;
      cfg_accept |=> !cfg_accept;
   endproperty
   a_acc_pulse: assert property (p_acc_pulse) else $error("accept too long");
   property p_cmd_answer;
      $rose(cfg_cmd) |-> ##[2:8] (cfg_accept || cfg_reject);
   endproperty
   a_cmd_answer: assert property (p_cmd_answer) else $error("no answer");
   property p_attn_pulse;
      status_attention |=> !status_attention;
   endproperty
   a_attn_pulse: assert property (p_attn_pulse) else $error("attention too long");
   property p_attn_cause;
      status_attention |-> since_op < 4'h6;
   endproperty
   a_attn_cause: assert property (p_attn_cause) else $error("stray attention");
endmodule : acr_element_asserts

bind acr_element acr_element_asserts u_asserts (.ref_clk, .rst_b, .reg_wr, .power_fault,
   .logout_stop_req, .cfg_cmd, .op_end, .select_attempt, .element_check_signal,
   .stopped_signal, .status_attention, .cfg_accept, .cfg_reject);

// *** testbench/acr_listener.sv ***
`timescale 1ns/1ns
module acr_listener (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic element_check_signal,
   input wire logic stop_en,
   input wire logic [9:0] stop_delay,
   output logic logout_stop_req,
   output logic [7:0] pulse_cnt
);
   logic [1:0] hist;
   logic [9:0] cnt;
   logic run;
   // ========
   // Pulse count and delayed logout-stop reply
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         hist <= 2'h0;
         cnt <= 10'h0;
         run <= 1'b0;
         pulse_cnt <= 8'h0;
         logout_stop_req <= 1'b0;
      end else begin
         hist <= {hist[0], element_check_signal};
         if (hist == 2'h1 && !element_check_signal)
            pulse_cnt <= pulse_cnt + 8'h1;
         cnt <= (!hist[0] && element_check_signal) ? 10'h0 : cnt + 10'h1;
         run <= (!hist[0] && element_check_signal) || (run && cnt < stop_delay + 10'h4);
         // Late replies miss the wait window on purpose
         logout_stop_req <= run && stop_en && cnt >= stop_delay && cnt < stop_delay + 10'h4;
      end
   end
endmodule : acr_listener

// *** testbench/acr_element_tb_top.sv ***
`timescale 1ns/1ns
module acr_element_tb_top
   import acr_pkg::*;
;
   logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic power_fault = 1'b0, power_down = 1'b0, over_temp_sense = 1'b0, over_temp_test = 1'b0;
   logic battery_sense = 1'b0, battery_test = 1'b0, logic_error = 1'b0, cfg_cmd = 1'b0;
   logic unable_to_continue = 1'b0, op_end = 1'b0, select_attempt = 1'b0, stop_en = 1'b0;
   logic [2:0] cfg_src = 3'h0;
   logic [8:0] cfg_data = 9'h0;
   logic [9:0] stop_delay = 10'h0;
   logic [7:0] pulse_cnt;
   logic logout_stop_req, element_check_signal, battery_power_signal, stopped_signal;
   logic ext_interrupt, status_attention, cfg_accept, cfg_reject;
   int error_cnt = 0, total_checks = 0, bat_cnt = 0, attn_cnt = 0;

   acr_element uut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .power_fault, .power_down, .over_temp_sense, .over_temp_test, .battery_sense,
      .battery_test, .logic_error, .unable_to_continue, .logout_stop_req, .cfg_cmd, .cfg_src,
      .cfg_data, .op_end, .select_attempt, .element_check_signal, .battery_power_signal,
      .stopped_signal, .ext_interrupt, .status_attention, .cfg_accept, .cfg_reject);
   acr_listener u_lis (.ref_clk, .rst_b, .element_check_signal, .stop_en, .stop_delay,
      .logout_stop_req, .pulse_cnt);

   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      bat_cnt <= bat_cnt + int'(battery_power_signal);
      attn_cnt <= attn_cnt + int'(status_attention);
   end

   // ========
   // Helpers
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   task automatic fail_out();
      error_cnt++;
      wrap_up();
   endtask : fail_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      check(reg_rdata, e);
   endtask : rdc
   // Fields settle before the command edge
   task automatic cmd(input logic [2:0] s, input logic [8:0] d, input logic acc);
      logic hit;
      hit = 1'b0;
      cfg_src <= s;
      cfg_data <= d;
      tick(4);
      cfg_cmd <= 1'b1;
      for (int i = 0; i < 12 && !hit; i++) begin
         @(posedge ref_clk);
         hit = cfg_accept | cfg_reject;
         if (hit)
            check({cfg_accept, cfg_reject}, {acc, !acc});
      end
      if (!hit)
         fail_out();
      cfg_cmd <= 1'b0;
      tick(3);
   endtask : cmd

   initial begin
      #1000000;
      fail_out();
   end

   // ========
   // Main sequence
   initial begin
      logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_CFG, ADDR_STATUS, ADDR_DIAG, ADDR_MASK, 8'h18};
      logic [31:0] rv [6] = '{32'h0, 32'(CFG_RESET), 32'h0, 32'h0, 32'h0, 32'h0};
      logic [7:0] n;
      int a;
      tick(3);
      rst_b <= 1'b1;
      foreach (ra[i])
         rdc(ra[i], rv[i]);
      $display("reset values done");
      for (int i = 0; i < 3; i++) begin
         power_fault <= (i == 0);
         power_down <= (i == 1);
         tick(6);
         check(element_check_signal, i < 2);
      end
      wr(ADDR_MASK, 32'h3);
      over_temp_test <= 1'b1;
      tick(6);
      check({element_check_signal, ext_interrupt}, 2'h0);
      wr(ADDR_CTRL, 32'h1 << CTRL_IRQ_EN);
      tick(3);
      check(ext_interrupt, 1'b1);
      rdc(ADDR_DIAG, 32'h1 << DIAG_OTC);
      rdc(ADDR_DIAG, 32'h1 << DIAG_OTC);
      over_temp_test <= 1'b0;
      battery_test <= 1'b1;
      tick(6);
      rdc(ADDR_DIAG, 32'h3);
      rdc(ADDR_DIAG, 32'h1 << DIAG_BAT);
      check(element_check_signal, 1'b0);
      wr(ADDR_MASK, 32'h1);
      tick(3);
      check(ext_interrupt, 1'b0);
      battery_test <= 1'b0;
      $display("computing element done");
      wr(ADDR_CTRL, 32'(KIND_SE));
      for (int i = 0; i < 3; i++) begin
         over_temp_sense <= (i == 0);
         battery_sense <= (i == 1);
         tick(6);
         check(element_check_signal, i < 2);
      end
      wr(ADDR_CTRL, 32'(KIND_IO_COMPUTING_ELEMENT));
      {over_temp_sense, battery_test} <= 2'h3;
      tick(6);
      check({element_check_signal, battery_power_signal}, 2'h3);
      {over_temp_sense, battery_test} <= 2'h0;
      tick(6);
      check({element_check_signal, battery_power_signal}, 2'h0);
      n = pulse_cnt;
      wr(ADDR_CFG, 32'h0ff);
      tick(8);
      check(pulse_cnt, n + 8'h1);
      a = bat_cnt;
      cmd(3'h0, 9'h1ff, 1'b1);
      tick(4);
      check(bat_cnt - a, 1);
      wr(ADDR_CFG, 32'h004);
      cmd(3'h2, 9'h004, 1'b1);
      cmd(3'h1, 9'h004, 1'b0);
      wr(ADDR_CFG, 32'h100);
      cmd(3'h1, 9'h100, 1'b0);
      wr(ADDR_CTRL, 32'(KIND_IO_COMPUTING_ELEMENT) | 32'h1 << CTRL_STATE_LSB);
      cmd(3'h5, 9'h020, 1'b1);
      rdc(ADDR_CFG, 32'h020);
      $display("configuration done");
      wr(ADDR_CTRL, 32'(KIND_DISK));
      n = pulse_cnt;
      over_temp_test <= 1'b1;
      tick(8);
      check({pulse_cnt, element_check_signal}, {n + 8'h1, 1'b0});
      over_temp_test <= 1'b0;
      tick(4);
      rdc(ADDR_SENSE, 32'h1 << SENSE_B4_OTC);
      rdc(ADDR_SENSE, 32'h0);
      // Reset again to return the registers to their reset values
      rst_b <= 1'b0;
      tick(3);
      rst_b <= 1'b1;
      wr(ADDR_CTRL, 32'(KIND_TAPE));
      a = attn_cnt;
      for (int i = 0; i < 4; i++) begin
         op_end <= (i == 0 || i == 3);
         over_temp_test <= (i > 0);
         select_attempt <= (i == 2);
         tick(6);
         check(attn_cnt - a, i > 1);
      end
      wr(ADDR_CTRL, 32'(KIND_PAM));
      tick(6);
      rdc(ADDR_SENSE, 32'h1 << SENSE_ADP_OTC);
      wr(ADDR_CFG, 32'h0ff);
      tick(4);
      rdc(ADDR_SENSE, 32'h1 << SENSE_ADP_OTC | 32'h1 << SENSE_ADP_PAR);
      wr(ADDR_CFG, 32'(CFG_RESET));
      tick(1);
      {op_end, over_temp_test, select_attempt} <= 3'h0;
      $display("io units done");
      wr(ADDR_CTRL, 32'(KIND_SE));
      stop_en <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         stop_delay <= (i == 0) ? 10'h014 : 10'h190;
         logic_error <= 1'b1;
         tick(300);
         check({stopped_signal, element_check_signal}, (i == 0) ? 2'h3 : 2'h0);
         logic_error <= 1'b0;
         wr(ADDR_CTRL, 32'(KIND_SE) | 32'h1 << CTRL_RESTART);
         tick(6);
         check({stopped_signal, element_check_signal}, 2'h0);
      end
      wr(ADDR_CTRL, 32'(KIND_CE));
      unable_to_continue <= 1'b1;
      tick(6);
      unable_to_continue <= 1'b0;
      tick(50);
      check(element_check_signal, 1'b1);
      rdc(ADDR_STATUS, 32'h1 << ST_CHECKSTOP);
      wr(ADDR_CTRL, 32'h1 << CTRL_RESTART);
      tick(6);
      check(element_check_signal, 1'b0);
      $display("checkstop done");
      wrap_up();
   end
endmodule : acr_element_tb_top
